// ### sbic_pkg.sv
// package: register map, field layout and types of the serial baud and interrupt control block
package sbic_pkg;
    localparam logic [15:0] SBIC_ADDR_TX_DONE_IC = 16'hff6c;
    localparam logic [15:0] SBIC_ADDR_RX_DONE_IC = 16'hff6e;
    localparam logic [15:0] SBIC_ADDR_TX_BUF_IC = 16'hff9c;
    localparam logic [15:0] SBIC_ADDR_RX_ERR_IC = 16'hff70;
    localparam logic [15:0] SBIC_ADDR_BAUD = 16'hfeb4;
    localparam logic [15:0] SBIC_ADDR_CTRL = 16'hffb0;
    localparam int SBIC_IC_REQ_BIT = 7;
    localparam int SBIC_IC_EN_BIT = 6;
    localparam int SBIC_IC_LVL_LSB = 2;
    localparam int SBIC_IC_GRP_LSB = 0;
    localparam int SBIC_CTRL_BRS_BIT = 13;
    localparam int SBIC_CTRL_RUN_BIT = 15;
    localparam int SBIC_CTRL_FE_BIT = 9;
    localparam int SBIC_CTRL_PE_BIT = 8;
    localparam int SBIC_CTRL_OE_BIT = 10;
    localparam logic [7:0] SBIC_IC_RESET = 8'h00;
    localparam logic [15:0] SBIC_WORD_RESET = 16'h0000;
    localparam int SBIC_SYNC_TICKS_PER_BIT = 4;
    localparam int SBIC_NUM_SRC = 4;
    localparam logic [7:0] SBIC_VEC_TX_DONE = 8'h2a;
    localparam logic [7:0] SBIC_VEC_TX_BUF = 8'h47;
    localparam logic [7:0] SBIC_VEC_RX_DONE = 8'h2b;
    localparam logic [7:0] SBIC_VEC_RX_ERR = 8'h2c;

    typedef struct packed {
        logic req;
        logic en;
        logic [3:0] lvl;
        logic [1:0] grp;
    } sbic_ic_t;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] bit_mask;
    } sbic_bus_t;

    typedef struct packed {
        logic framing;
        logic parity;
        logic overrun;
    } sbic_fault_t;
endpackage

// ### sbic_top.sv
// serial baud generator (synchronous mode) and four-source interrupt control
// Operation
// (R01) generator delivers ticks at four times bit rate; each bit spans four ticks
// (R02) bit rate = clk / 4 / (2 + prescale) / (reload + 1), 13-bit reload
// (R03) four requests: tx done, tx buffer, rx done, error, each own vector
// (R04) interrupt control registers are bit addressable via per-bit write mask
// (R05) error request auto-clears at service entry; fault flags stay until software clears
// (R06) control register shows framing, parity and overrun fault flags separately
// (R07) control: request bit 7, enable bit 6, level 5..2, group 1..0, reset zero
// (R08) timer counts down at half clock while running, ticks and reloads on underflow
// (R09) prescale one divides tick stream to two thirds before mode division
// (R10) baud read gives timer with 15..13 zero; write reloads, deferred while stopped
// (R11) request forwarded only while enabled; flags stay pending regardless
`timescale 1ns/1ps
module sbic_top
    import sbic_pkg::*;
#(
    parameter int RELOAD_W = 13
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register access
    input wire sbic_bus_t bus,
    output logic [15:0] rdata,
    // channel events
    input wire logic tx_done_event,
    input wire logic tx_buf_event,
    input wire logic rx_done_event,
    input wire logic rx_err_event,
    input wire sbic_fault_t fault_event,
    // service entry acknowledge per source: tx done, tx buf, rx done, error
    input wire logic [3:0] irq_ack,
    // baud outputs
    output logic baud_tick,
    output logic bit_tick,
    // interrupt requests to the system interrupt logic
    output logic [3:0] irq_req,
    output logic [7:0] irq_vector [4]
);
    initial begin
        if (RELOAD_W != 13) $error("reload width must be 13");
    end

    sbic_ic_t ic_r [SBIC_NUM_SRC];
    logic [RELOAD_W-1:0] timer_r, reload_r;
    logic half_r, pend_reload_r, run_r, brs_r;
    logic [1:0] third_r, quarter_r;
    sbic_fault_t fault_r;
    logic tick_r, bit_r;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        return a == b;
    endfunction

    wire logic [15:0] ic_addr [4] = '{SBIC_ADDR_TX_DONE_IC, SBIC_ADDR_TX_BUF_IC,
                                      SBIC_ADDR_RX_DONE_IC, SBIC_ADDR_RX_ERR_IC};
    wire logic [3:0] src_event = {rx_err_event, rx_done_event, tx_buf_event, tx_done_event}; // R03
    wire logic wr_baud = bus.sel && bus.wr && hit(bus.addr, SBIC_ADDR_BAUD);
    wire logic wr_ctrl = bus.sel && bus.wr && hit(bus.addr, SBIC_ADDR_CTRL);
    wire logic underflow = run_r && half_r && (timer_r == '0); // R08
    wire logic [15:0] ctrl_word = {run_r, 1'b0, brs_r, 2'b00, fault_r.overrun, fault_r.framing,
                                   fault_r.parity, 8'h00}; // R06
    wire logic [15:0] ctrl_new = (ctrl_word & ~bus.bit_mask) | (bus.wdata & bus.bit_mask);
    // prescale one swallows every third tick, giving two thirds of the rate
    wire logic third_pass = !brs_r || (third_r != 2'd2); // R09

    genvar g;
    generate
        for (g = 0; g < SBIC_NUM_SRC; g++) begin : gen_ic
            wire logic wr_ic = bus.sel && bus.wr && hit(bus.addr, ic_addr[g]);
            wire logic [7:0] merged = (ic_r[g] & ~bus.bit_mask[7:0])
                                      | (bus.wdata[7:0] & bus.bit_mask[7:0]); // R04
            sbic_ic_t ic_nxt;
            always_comb begin
                ic_nxt = ic_r[g];
                if (wr_ic) ic_nxt = sbic_ic_t'(merged); // R07
                if (irq_ack[g]) ic_nxt.req = 1'b0; // R05
                if (src_event[g]) ic_nxt.req = 1'b1;
            end
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) ic_r[g] <= sbic_ic_t'(SBIC_IC_RESET); // R07
                else ic_r[g] <= ic_nxt;
            end
            assign irq_req[g] = ic_r[g].req && ic_r[g].en; // R11
        end
    endgenerate

    assign irq_vector[0] = SBIC_VEC_TX_DONE;
    assign irq_vector[1] = SBIC_VEC_TX_BUF;
    assign irq_vector[2] = SBIC_VEC_RX_DONE;
    assign irq_vector[3] = SBIC_VEC_RX_ERR; // R03

    // fault flags: hardware sets win over software clears; no auto-clear on service entry
    wire logic fe_nxt = fault_event.framing || (wr_ctrl ? ctrl_new[SBIC_CTRL_FE_BIT]
                                                        : fault_r.framing); // R05
    wire logic pe_nxt = fault_event.parity || (wr_ctrl ? ctrl_new[SBIC_CTRL_PE_BIT]
                                                       : fault_r.parity);
    wire logic oe_nxt = fault_event.overrun || (wr_ctrl ? ctrl_new[SBIC_CTRL_OE_BIT]
                                                        : fault_r.overrun);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            run_r <= 1'b0;
            brs_r <= 1'b0;
            fault_r <= '0;
        end else begin
            if (wr_ctrl) run_r <= ctrl_new[SBIC_CTRL_RUN_BIT];
            if (wr_ctrl) brs_r <= ctrl_new[SBIC_CTRL_BRS_BIT];
            fault_r <= '{framing: fe_nxt, parity: pe_nxt, overrun: oe_nxt}; // R06
        end
    end

    // baud timer at half the system clock
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            timer_r <= '0;
            reload_r <= '0;
            half_r <= 1'b0;
            pend_reload_r <= 1'b0;
        end else begin
            half_r <= run_r ? ~half_r : 1'b0; // R08
            if (wr_baud) begin
                reload_r <= bus.wdata[RELOAD_W-1:0]; // R10
                if (run_r) timer_r <= bus.wdata[RELOAD_W-1:0];
                pend_reload_r <= !run_r;
            end else if (run_r && pend_reload_r) begin
                timer_r <= reload_r; // R10
                pend_reload_r <= 1'b0;
            end else if (underflow) begin
                timer_r <= reload_r; // R08
            end else if (run_r && half_r) begin
                timer_r <= timer_r - 1'b1;
            end
        end
    end

    // tick stream, two-thirds prescale and the divide by four per bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            third_r <= 2'd0;
            quarter_r <= 2'd0;
            tick_r <= 1'b0;
            bit_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            bit_r <= 1'b0;
            if (underflow) begin
                third_r <= (third_r == 2'd2) ? 2'd0 : third_r + 2'd1; // R09
                if (third_pass) begin
                    tick_r <= 1'b1; // R01
                    quarter_r <= quarter_r + 2'd1; // R02
                    bit_r <= (quarter_r == 2'(SBIC_SYNC_TICKS_PER_BIT - 1)); // R01
                end
            end
        end
    end

    assign baud_tick = tick_r;
    assign bit_tick = bit_r;

    // read decode
    always_comb begin
        rdata = 16'h0000;
        if (bus.sel && bus.rd) begin
            if (hit(bus.addr, SBIC_ADDR_BAUD)) rdata = {3'b000, timer_r}; // R10
            else if (hit(bus.addr, SBIC_ADDR_CTRL)) rdata = ctrl_word;
            else begin
                for (int i = 0; i < SBIC_NUM_SRC; i++)
                    if (hit(bus.addr, ic_addr[i])) rdata = {8'h00, ic_r[i]};
            end
        end
    end
endmodule

// ### sbic_asserts.sv
// checker: port-level properties of the baud and interrupt control block
`timescale 1ns/1ps
module sbic_asserts
    import sbic_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // watched ports
    input wire sbic_bus_t bus,
    input wire logic [15:0] rdata,
    input wire logic rx_err_event,
    input wire logic [3:0] irq_ack,
    input wire logic baud_tick,
    input wire logic bit_tick,
    input wire logic [3:0] irq_req,
    input wire logic [7:0] irq_vector [4]
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    wire rd_w = bus.sel && bus.rd;
    wire wr_w = bus.sel && bus.wr;
    vec_fixed_a: assert property (irq_vector[3] == SBIC_VEC_RX_ERR)
        else $error("error vector moved");
    ack_clears_a: assert property (irq_ack[3] && !rx_err_event && !wr_w |=> !irq_req[3])
        else $error("error request survived service entry");
    tick_space_a: assert property (baud_tick |=> !baud_tick)
        else $error("baud ticks back to back");
    bit_space_a: assert property (bit_tick |=> !bit_tick [*7])
        else $error("bit ticks closer than four baud ticks");
    req_cause_a: assert property ($rose(irq_req[3]) |-> $past(rx_err_event || wr_w))
        else $error("error request rose without cause");
    baud_read_a: assert property (rd_w && bus.addr == SBIC_ADDR_BAUD |-> rdata[15:13] == 3'h0)
        else $error("baud read upper bits set");
    ic_read_a: assert property (rd_w && bus.addr == SBIC_ADDR_TX_DONE_IC |-> rdata[15:8] == 8'h00)
        else $error("control upper byte set");
    err_fwd_a: assert property (rd_w && bus.addr == SBIC_ADDR_RX_ERR_IC |->
        irq_req[3] == (rdata[7] && rdata[6]))
        else $error("error request not flag and enable");
endmodule

// ### sbic_partner.sv
// partner: remote serial device raising channel events
`timescale 1ns/1ps
module sbic_partner (
    // clock
    input wire logic clk_sys,
    // event commands and pulses
    input wire logic [3:0] fire,
    output logic [3:0] ev
);
    initial ev = 4'h0;
    // registered so each event repeats its fire command one cycle later, as wide as the command
    always @(posedge clk_sys) ev <= fire;
endmodule

// ### sbic_tb.sv
// testbench: register sequences, events and baud timing of the block
`timescale 1ns/1ps
module testbench
    import sbic_pkg::*;
;
    logic clk_sys = 0, arst_n = 0, btk, bit_t;
    sbic_bus_t b = '0;
    sbic_fault_t flt = '0;
    logic [15:0] rdata;
    logic [3:0] fire = '0, ev, ack = '0, req;
    logic [7:0] vec [4];
    logic [7:0] vec_exp [4] = '{SBIC_VEC_TX_DONE, SBIC_VEC_TX_BUF, SBIC_VEC_RX_DONE,
        SBIC_VEC_RX_ERR};
    logic [15:0] ic_a [4] = '{SBIC_ADDR_TX_DONE_IC, SBIC_ADDR_TX_BUF_IC,
        SBIC_ADDR_RX_DONE_IC, SBIC_ADDR_RX_ERR_IC};
    int errors = 0, num_checks = 0, cyc = 0;
    initial forever #25 clk_sys = ~clk_sys;
    sbic_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .bus(b), .rdata(rdata),
        .tx_done_event(ev[0]), .tx_buf_event(ev[1]), .rx_done_event(ev[2]),
        .rx_err_event(ev[3]), .fault_event(flt), .irq_ack(ack), .baud_tick(btk),
        .bit_tick(bit_t), .irq_req(req), .irq_vector(vec));
    sbic_partner far (.clk_sys(clk_sys), .fire(fire), .ev(ev));
    task chk(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step(); @(posedge clk_sys); #1; endtask
    task wr(input logic [15:0] a, d, m);
        b = '{1'b1, 1'b1, 1'b0, a, d, m};
        step();
        b = '0;
        // idle cycle so the next call never re-drives the bus in this time step
        step();
    endtask
    task rd(input logic [15:0] a, exp);
        b = '{1'b1, 1'b0, 1'b1, a, 16'h0000, 16'h0000};
        #1 chk(rdata, exp);
        step();
        b = '0;
        step();
    endtask
    // bit period in cycles; zero expectation only resynchronises
    task gap(input int exp);
        int n, m;
        n = 0;
        m = 0;
        while (bit_t !== 1'b1) step();
        do begin
            step();
            n++;
            if (btk === 1'b1) m++;
        end while (bit_t !== 1'b1);
        if (exp > 0) chk(16'(n), 16'(exp));
        if (exp > 0) chk(16'(m), 16'(SBIC_SYNC_TICKS_PER_BIT));
    endtask
    task finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin errors++; finish_test(); end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        #1 arst_n = 1;
        foreach (ic_a[i]) rd(ic_a[i], 16'h0000);
        foreach (vec[i]) chk(16'(vec[i]), 16'(vec_exp[i]));
        flt = '{1'b1, 1'b0, 1'b1};
        step();
        flt = '0;
        $display("reset test done");
        foreach (ic_a[i]) begin
            wr(ic_a[i], 16'h00ff, 16'h0040);
            wr(ic_a[i], 16'h0014, 16'h003c);
            rd(ic_a[i], 16'h0054);
            chk(16'(req), 16'h0000);
            fire = 4'h1 << i;
            step();
            fire = '0;
            step();
            rd(ic_a[i], 16'h00d4);
            chk(16'(req), 16'(4'h1 << i));
            wr(ic_a[i], 16'h0000, 16'h0040);
            chk(16'(req), 16'h0000);
            rd(ic_a[i], 16'h0094);
            ack = 4'h1 << i;
            step();
            ack = '0;
            rd(ic_a[i], 16'h0014);
            wr(ic_a[i], 16'hffff, 16'h0080);
            rd(ic_a[i], 16'h0094);
            wr(ic_a[i], 16'h0000, 16'hffff);
        end
        rd(SBIC_ADDR_CTRL, 16'h0600);
        wr(SBIC_ADDR_CTRL, 16'h0000, 16'h0700);
        rd(SBIC_ADDR_CTRL, 16'h0000);
        wr(16'hff00, 16'hffff, 16'hffff);
        rd(16'hff00, 16'h0000);
        $display("interrupt test done");
        wr(SBIC_ADDR_BAUD, 16'he003, 16'hffff);
        rd(SBIC_ADDR_BAUD, 16'h0000);
        wr(SBIC_ADDR_CTRL, 16'h8000, 16'h8000);
        gap(0);
        gap(4 * 2 * 4);
        wr(SBIC_ADDR_CTRL, 16'h2000, 16'h2000);
        gap(0);
        gap(4 * 3 * 4);
        $display("baud test done");
        finish_test();
    end
endmodule
bind sbic_top sbic_asserts chk_i (.clk_sys(clk_sys), .arst_n(arst_n), .bus(bus),
    .rdata(rdata), .rx_err_event(rx_err_event), .irq_ack(irq_ack),
    .baud_tick(baud_tick), .bit_tick(bit_tick), .irq_req(irq_req),
    .irq_vector(irq_vector));
